// [core/dtc_dma_core.sv]
// channel start, chaining, credit pacing, pacing timers and interrupt lines of a dma controller
`default_nettype none
`include "dtc_defines.svh"
module dtc_dma_core
   import dtc_pkg::*;
#(
   parameter int NCH = 12,
   parameter int NDREQ = 40,
   parameter int CREDIT_W = 6,
   parameter int INFL_W = 4
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [NDREQ-1:0] dreq,
   input wire logic [NCH-1:0] xfer_issue,
   input wire logic [NCH-1:0] xfer_done,
   input wire logic fifo_valid,
   input wire logic [3:0] fifo_chan,
   output logic [NCH-1:0] xfer_req,
   output logic [NCH-1:0] chan_busy,
   output logic irq0,
   output logic irq1,
   output logic sniff_strobe
);

   // bus slave state
   logic take;
   logic aph_wr_r;
   logic aph_rd_r;
   logic [11:0] aph_addr_r;
   logic ch_hit;
   logic [3:0] ch_sel;
   logic [3:0] ch_off;

   // per-channel state
   dtc_state_t state_r [NCH];
   dtc_state_t state_nxt [NCH];
   logic [11:0] ctrl_r [NCH];
   logic [11:0] ctrl_nxt [NCH];
   logic [31:0] reload_r [NCH];
   logic [31:0] reload_nxt [NCH];
   logic [31:0] live_r [NCH];
   logic [31:0] live_nxt [NCH];
   logic [INFL_W-1:0] infl_r [NCH];
   logic [INFL_W-1:0] infl_nxt [NCH];
   logic [CREDIT_W-1:0] credit_r [NCH];
   logic [CREDIT_W-1:0] credit_nxt [NCH];
   logic [NCH-1:0] start;
   logic [NCH-1:0] complete;
   logic [NCH-1:0] null_trig;
   logic [NCH-1:0] chain_hit;
   logic [NCH-1:0] req_nxt;

   // interrupts
   logic [NCH-1:0] raw_r;
   logic [NCH-1:0] raw_nxt;
   logic [NCH-1:0] irq_line0_channel_mask_r;
   logic [NCH-1:0] irq_line1_channel_mask_r;
   logic [NCH-1:0] intf0_r;
   logic [NCH-1:0] intf1_r;
   logic [NCH-1:0] ints0;
   logic [NCH-1:0] ints1;

   // pacing timers and checksum tap selection
   logic [31:0] tmr_r [`DTC_NTIMER];
   logic [15:0] acc_r [`DTC_NTIMER];
   logic [`DTC_NTIMER-1:0] tpulse_r;
   logic [4:0] sniff_r;
   logic [31:0] rd_mux;

   function automatic logic pace_pulse(input logic [5:0] sel,
                                       input logic [NDREQ-1:0] rq,
                                       input logic [`DTC_NTIMER-1:0] tp);
      logic hit;
      hit = 1'b0;
      if (32'(sel) < NDREQ) begin
         hit = rq[sel];
      end else if (sel >= `DTC_SEL_TIMER0 && sel < `DTC_SEL_NONE) begin
         hit = tp[2'(sel - `DTC_SEL_TIMER0)];
      end
      return hit;
   endfunction

   function automatic logic glb_wr(input logic wr, input logic [11:0] a,
                                   input logic [11:0] off);
      return wr && (a == off);
   endfunction

   assign take = hsel & hready & htrans[1];
   assign ch_sel = aph_addr_r[7:4];
   assign ch_off = aph_addr_r[3:0];
   assign ch_hit = (aph_addr_r < `DTC_GLB_BASE) && (32'(aph_addr_r[11:4]) < NCH);
   assign ints0 = (raw_r & irq_line0_channel_mask_r) | intf0_r;
   assign ints1 = (raw_r & irq_line1_channel_mask_r) | intf1_r;

   // address phase capture; reads take one wait state so hrdata comes from a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aph_wr_r <= 1'b0;
         aph_rd_r <= 1'b0;
         aph_addr_r <= 12'h000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         aph_wr_r <= take & hwrite;
         aph_rd_r <= take & ~hwrite;
         if (take) begin
            aph_addr_r <= {haddr[11:2], 2'b00};
         end
         hreadyout <= ~(take & ~hwrite);
         hresp <= 1'b0;
      end
   end

   // chain triggers from channels completing this cycle
   always_comb begin
      chain_hit = '0;
      for (int j = 0; j < NCH; j++) begin
         if (complete[j] && ctrl_r[j][`DTC_CHAIN_MSB:`DTC_CHAIN_LSB] != 4'(j) &&
             32'(ctrl_r[j][`DTC_CHAIN_MSB:`DTC_CHAIN_LSB]) < NCH) begin
            chain_hit[ctrl_r[j][`DTC_CHAIN_MSB:`DTC_CHAIN_LSB]] = 1'b1;
         end
      end
   end

   // per-channel next state
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         logic sel_ch;
         logic trig_wr;
         logic paced;
         logic issue;
         sel_ch = aph_wr_r && ch_hit && (ch_sel == 4'(i));
         trig_wr = sel_ch && (ch_off == `DTC_CH_CTRL_TRIG || ch_off == `DTC_CH_TCOUNT_TRIG);
         ctrl_nxt[i] = ctrl_r[i];
         if (sel_ch && (ch_off == `DTC_CH_CTRL || ch_off == `DTC_CH_CTRL_TRIG)) begin
            ctrl_nxt[i] = hwdata[11:0];
         end
         reload_nxt[i] = reload_r[i];
         if (sel_ch && (ch_off == `DTC_CH_TCOUNT || ch_off == `DTC_CH_TCOUNT_TRIG)) begin
            reload_nxt[i] = hwdata;
         end
         complete[i] = (state_r[i] == DTC_RUN) && (live_r[i] == 32'h0000_0000) &&
                       (infl_r[i] == '0);
         null_trig[i] = trig_wr && (hwdata == 32'h0000_0000);
         start[i] = ((trig_wr && hwdata != 32'h0000_0000) || chain_hit[i]) &&
                    ctrl_nxt[i][`DTC_EN_BIT] &&
                    (state_r[i] == DTC_IDLE);
         paced = ctrl_r[i][`DTC_SEL_MSB:`DTC_SEL_LSB] != `DTC_SEL_NONE;
         issue = xfer_issue[i] && (state_r[i] == DTC_RUN) && (live_r[i] != 32'h0000_0000);
         state_nxt[i] = state_r[i];
         live_nxt[i] = live_r[i];
         infl_nxt[i] = infl_r[i];
         if (start[i]) begin
            state_nxt[i] = DTC_RUN;
            live_nxt[i] = reload_nxt[i];
         end else if (complete[i]) begin
            state_nxt[i] = DTC_IDLE;
         end else if (issue) begin
            live_nxt[i] = live_r[i] - 32'h0000_0001;
         end
         if (issue && !xfer_done[i]) begin
            infl_nxt[i] = infl_r[i] + 1'b1;
         end else if (!issue && xfer_done[i] && infl_r[i] != '0) begin
            infl_nxt[i] = infl_r[i] - 1'b1;
         end
         credit_nxt[i] = credit_r[i];
         if (pace_pulse(ctrl_r[i][`DTC_SEL_MSB:`DTC_SEL_LSB], dreq, tpulse_r) &&
             !(issue && paced)) begin
            if (credit_r[i] != '1) begin
               credit_nxt[i] = credit_r[i] + 1'b1;
            end
         end else if (!pace_pulse(ctrl_r[i][`DTC_SEL_MSB:`DTC_SEL_LSB], dreq, tpulse_r) &&
                      issue && paced && credit_r[i] != '0) begin
            credit_nxt[i] = credit_r[i] - 1'b1;
         end
         // request is built from next values so a grant never outruns the credit
         req_nxt[i] = (state_nxt[i] == DTC_RUN) && ctrl_nxt[i][`DTC_EN_BIT] &&
                      (live_nxt[i] != 32'h0000_0000) &&
                      (!paced || credit_nxt[i] != '0);
      end
   end

   // channel registers and counters
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < NCH; i++) begin
            state_r[i] <= DTC_IDLE;
            ctrl_r[i] <= `DTC_CTRL_RST | (12'(i) << `DTC_CHAIN_LSB);
            reload_r[i] <= 32'h0000_0000;
            live_r[i] <= 32'h0000_0000;
            infl_r[i] <= '0;
            credit_r[i] <= '0;
         end
         xfer_req <= '0;
         chan_busy <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            state_r[i] <= state_nxt[i];
            ctrl_r[i] <= ctrl_nxt[i];
            reload_r[i] <= reload_nxt[i];
            live_r[i] <= live_nxt[i];
            infl_r[i] <= infl_nxt[i];
            credit_r[i] <= credit_nxt[i];
            chan_busy[i] <= state_nxt[i] == DTC_RUN;
         end
         xfer_req <= req_nxt;
      end
   end

   // pending interrupts: a set in the same cycle as its clear wins
   always_comb begin
      logic [NCH-1:0] clr;
      logic [NCH-1:0] set;
      clr = '0;
      set = '0;
      if (glb_wr(aph_wr_r, aph_addr_r, `DTC_INTS0) || glb_wr(aph_wr_r, aph_addr_r, `DTC_INTS1)) begin
         clr = hwdata[NCH-1:0];
      end
      for (int i = 0; i < NCH; i++) begin
         set[i] = (complete[i] && !ctrl_r[i][`DTC_QUIET_BIT]) ||
                  (null_trig[i] && ctrl_r[i][`DTC_QUIET_BIT]);
      end
      raw_nxt = (raw_r & ~clr) | set;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         raw_r <= '0;
         irq_line0_channel_mask_r <= '0;
         irq_line1_channel_mask_r <= '0;
         intf0_r <= '0;
         intf1_r <= '0;
         irq0 <= 1'b0;
         irq1 <= 1'b0;
      end else begin
         raw_r <= raw_nxt;
         if (glb_wr(aph_wr_r, aph_addr_r, `DTC_IRQ_LINE0_CHANNEL_MASK)) begin
            irq_line0_channel_mask_r <= hwdata[NCH-1:0];
         end
         if (glb_wr(aph_wr_r, aph_addr_r, `DTC_IRQ_LINE1_CHANNEL_MASK)) begin
            irq_line1_channel_mask_r <= hwdata[NCH-1:0];
         end
         if (glb_wr(aph_wr_r, aph_addr_r, `DTC_INTF0)) begin
            intf0_r <= hwdata[NCH-1:0];
         end
         if (glb_wr(aph_wr_r, aph_addr_r, `DTC_INTF1)) begin
            intf1_r <= hwdata[NCH-1:0];
         end
         irq0 <= |ints0;
         irq1 <= |ints1;
      end
   end

   // fractional pacing timers: word holds x in the upper half, y in the lower
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int t = 0; t < `DTC_NTIMER; t++) begin
            tmr_r[t] <= 32'h0000_0000;
            acc_r[t] <= 16'h0000;
         end
         tpulse_r <= '0;
      end else begin
         for (int t = 0; t < `DTC_NTIMER; t++) begin
            logic [15:0] x;
            logic [16:0] sum;
            x = (tmr_r[t][31:16] > tmr_r[t][15:0]) ? tmr_r[t][15:0] : tmr_r[t][31:16];
            sum = {1'b0, acc_r[t]} + {1'b0, x};
            if (glb_wr(aph_wr_r, aph_addr_r, `DTC_TIMER0 + 12'(t * 4))) begin
               tmr_r[t] <= hwdata;
               acc_r[t] <= 16'h0000;
               tpulse_r[t] <= 1'b0;
            end else if (x == 16'h0000) begin
               acc_r[t] <= 16'h0000;
               tpulse_r[t] <= 1'b0;
            end else if (sum >= {1'b0, tmr_r[t][15:0]}) begin
               acc_r[t] <= 16'(sum - {1'b0, tmr_r[t][15:0]});
               tpulse_r[t] <= 1'b1;
            end else begin
               acc_r[t] <= sum[15:0];
               tpulse_r[t] <= 1'b0;
            end
         end
      end
   end

   // checksum tap: a strobe for the selected channel's words, data never routed here
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sniff_r <= 5'h00;
         sniff_strobe <= 1'b0;
      end else begin
         if (glb_wr(aph_wr_r, aph_addr_r, `DTC_SNIFF)) begin
            sniff_r <= hwdata[4:0];
         end
         sniff_strobe <= fifo_valid && sniff_r[`DTC_SNIFF_EN_BIT] &&
                         (fifo_chan == sniff_r[3:0]);
      end
   end

   // read mux, sampled in the read wait state
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (ch_hit) begin
         if (ch_off == `DTC_CH_TCOUNT || ch_off == `DTC_CH_TCOUNT_TRIG) begin
            rd_mux = live_r[ch_sel];
         end else begin
            rd_mux[11:0] = ctrl_r[ch_sel];
            rd_mux[`DTC_BUSY_BIT] = state_r[ch_sel] == DTC_RUN;
         end
      end else begin
         unique case (aph_addr_r)
            `DTC_INTR: rd_mux[NCH-1:0] = raw_r;
            `DTC_IRQ_LINE0_CHANNEL_MASK: rd_mux[NCH-1:0] = irq_line0_channel_mask_r;
            `DTC_INTF0: rd_mux[NCH-1:0] = intf0_r;
            `DTC_INTS0: rd_mux[NCH-1:0] = ints0;
            `DTC_IRQ_LINE1_CHANNEL_MASK: rd_mux[NCH-1:0] = irq_line1_channel_mask_r;
            `DTC_INTF1: rd_mux[NCH-1:0] = intf1_r;
            `DTC_INTS1: rd_mux[NCH-1:0] = ints1;
            `DTC_SNIFF: rd_mux[4:0] = sniff_r;
            default: begin
               if (aph_addr_r >= `DTC_TIMER0 && aph_addr_r <= `DTC_TIMER3) begin
                  rd_mux = tmr_r[aph_addr_r[3:2]];
               end
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (aph_rd_r) begin
         hrdata <= rd_mux;
      end
   end

endmodule
`default_nettype wire

// [core/dtc_defines.svh]
// register offsets, field positions, reset values and counts of the trigger/chain/pacing core
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH
`define DTC_CH_TCOUNT 4'h0
`define DTC_CH_CTRL_TRIG 4'h4
`define DTC_CH_CTRL 4'h8
`define DTC_CH_TCOUNT_TRIG 4'hc
`define DTC_GLB_BASE 12'h400
`define DTC_INTR 12'h400
`define DTC_IRQ_LINE0_CHANNEL_MASK 12'h404
`define DTC_INTF0 12'h408
`define DTC_INTS0 12'h40c
`define DTC_IRQ_LINE1_CHANNEL_MASK 12'h410
`define DTC_INTF1 12'h414
`define DTC_INTS1 12'h418
`define DTC_TIMER0 12'h420
`define DTC_TIMER3 12'h42c
`define DTC_SNIFF 12'h430
`define DTC_EN_BIT 0
`define DTC_QUIET_BIT 1
`define DTC_SEL_LSB 2
`define DTC_SEL_MSB 7
`define DTC_CHAIN_LSB 8
`define DTC_CHAIN_MSB 11
`define DTC_BUSY_BIT 24
`define DTC_CTRL_RST 12'h0fc
`define DTC_SEL_TIMER0 6'h3b
`define DTC_SEL_NONE 6'h3f
`define DTC_NTIMER 4
`define DTC_SNIFF_EN_BIT 4
`endif

// [core/dtc_pkg.sv]
// types shared by the trigger/chain/pacing core
`default_nettype none
package dtc_pkg;
   typedef enum logic [0:0] {
      DTC_IDLE = 1'b0,
      DTC_RUN = 1'b1
   } dtc_state_t;
endpackage
`default_nettype wire

// [verif/dtc_dma_core_asserts.sv]
// concurrent checks on the ports of the trigger, chain, pacing and interrupt core
`default_nettype none
module dtc_dma_core_asserts #(
   parameter int NCH = 12
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic fifo_valid,
   input wire logic [NCH-1:0] xfer_req,
   input wire logic [NCH-1:0] chan_busy,
   input wire logic irq0,
   input wire logic irq1,
   input wire logic sniff_strobe
);
   logic wph_r;
   logic [11:0] wad_r;
   logic wd;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // remembers the address phase so the data phase edge can be recognised
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wph_r <= 1'b0;
         wad_r <= 12'h000;
      end else if (hready) begin
         wph_r <= hsel & htrans[1] & hwrite;
         wad_r <= haddr[11:0];
      end
   end
   assign wd = wph_r & hready;
   AST_START: assert property (
      wd && wad_r == 12'h004 && hwdata[0] && !chan_busy[0] |=> chan_busy[0])
      else $error("enabled trigger left channel 0 idle");
   AST_EN_CLEAR: assert property (
      wd && wad_r == 12'h004 && !hwdata[0] && chan_busy == '0 |=> !chan_busy[0])
      else $error("disabled trigger started channel 0");
   AST_NULL: assert property (
      wd && wad_r == 12'h00c && hwdata == 32'h0 && chan_busy == '0 |=> !chan_busy[0])
      else $error("null trigger started channel 0");
   AST_REQ_BUSY: assert property (
      (xfer_req & ~chan_busy) == '0)
      else $error("idle channel requests a transfer");
   AST_LIVE_HOLD: assert property (
      ($past(chan_busy & xfer_req) & ~chan_busy) == '0)
      else $error("channel completed with transfers left");
   AST_SNIFF: assert property (
      sniff_strobe |-> $past(fifo_valid))
      else $error("sniff strobe without a word in the fifo");
   AST_FORCE0: assert property (
      wd && wad_r == 12'h408 && hwdata[NCH-1:0] != '0 |-> ##2 irq0)
      else $error("force bits did not raise line 0");
   AST_FORCE1: assert property (
      wd && wad_r == 12'h414 && hwdata[NCH-1:0] != '0 |-> ##2 irq1)
      else $error("force bits did not raise line 1");
endmodule
bind dtc_dma_core dtc_dma_core_asserts #(.NCH(NCH)) u_asserts (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .fifo_valid(fifo_valid), .xfer_req(xfer_req),
   .chan_busy(chan_busy), .irq0(irq0), .irq1(irq1), .sniff_strobe(sniff_strobe));
`default_nettype wire

// [verif/dtc_fab_model.sv]
// arbiter and fabric stand-in: issues transfers to requesting channels and retires them
`default_nettype none
module dtc_fab_model #(
   parameter int NCH = 12
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic stall,
   input wire logic [NCH-1:0] xfer_req,
   output logic [NCH-1:0] xfer_issue,
   output logic [NCH-1:0] xfer_done,
   output logic fifo_valid,
   output logic [3:0] fifo_chan
);
   timeunit 1ns;
   timeprecision 1ps;
   // only the fabric is modelled, nothing else ever touches a serviced fifo
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         xfer_issue <= '0;
         xfer_done <= '0;
         fifo_valid <= 1'b0;
         fifo_chan <= 4'h0;
      end else begin
         xfer_issue <= stall ? '0 : (xfer_req & ~xfer_issue);
         xfer_done <= xfer_issue;
         fifo_valid <= |xfer_issue;
         for (int i = NCH - 1; i >= 0; i--) begin
            if (xfer_issue[i]) begin
               fifo_chan <= 4'(i);
            end
         end
      end
   end
endmodule
`default_nettype wire

// [verif/test_dtc_dma_core.sv]
// self-checking bench for the trigger, chain, pacing and interrupt core
`default_nettype none
module test_dtc_dma_core;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NCH = 12;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic stall = 1'b0;
   logic [39:0] dreq = '0;
   logic [31:0] hrdata, rv;
   logic hreadyout, hresp, irq0, irq1, sniff_strobe, fifo_valid;
   logic [NCH-1:0] xfer_issue, xfer_done, xfer_req, chan_busy;
   logic [3:0] fifo_chan;
   int num_errors = 0;
   int comparisons = 0;
   int iss[NCH];
   int snf = 0;
   always #5 hclk = ~hclk;
   always @(posedge hclk) begin
      snf += int'(sniff_strobe === 1'b1);
      for (int i = 0; i < NCH; i++) begin
         iss[i] += int'(xfer_issue[i] === 1'b1);
      end
   end
   dtc_dma_core #(.NCH(NCH)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .dreq(dreq), .xfer_issue(xfer_issue), .xfer_done(xfer_done),
      .fifo_valid(fifo_valid), .fifo_chan(fifo_chan), .xfer_req(xfer_req),
      .chan_busy(chan_busy), .irq0(irq0), .irq1(irq1), .sniff_strobe(sniff_strobe));
   dtc_fab_model #(.NCH(NCH)) u_fab (.hclk(hclk), .hresetn(hresetn), .stall(stall),
      .xfer_req(xfer_req), .xfer_issue(xfer_issue), .xfer_done(xfer_done),
      .fifo_valid(fifo_valid), .fifo_chan(fifo_chan));
   task automatic results;
      if (num_errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wt;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 100) begin
            num_errors++;
            results;
         end
         @(posedge hclk);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= 1'b1;
      wt;
      htrans <= 2'h0;
      hwdata <= d;
      wt;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= 1'b0;
      wt;
      htrans <= 2'h0;
      wt;
      rv = hrdata;
      chk(nm, rv, exp);
      chk("hresp", 32'(hresp), 32'h0);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic wbusy(input int c, input logic v);
      int n;
      n = 0;
      while (chan_busy[c] !== v) begin
         n++;
         if (n > 3000) begin
            num_errors++;
            results;
         end
         @(posedge hclk);
      end
   endtask
   task automatic t_regs;
      rd(12'h018, 32'h1fc, "ctrl1 reset");
      rd(12'h7f0, 32'h0, "unmapped");
      rd(12'h400, 32'h0, "raw reset");
   endtask
   task automatic t_start;
      int n;
      wr(12'h008, 32'h0fd);
      wr(12'h004, 32'h0fc);
      cyc(2);
      chk("busy0 disabled", 32'(chan_busy[0]), 32'h0);
      wr(12'h000, 32'h2);
      wr(12'h404, 32'h1);
      n = iss[0];
      wr(12'h004, 32'h0fd);
      cyc(1);
      chk("busy0 started", 32'(chan_busy[0]), 32'h1);
      wbusy(0, 1'b0);
      cyc(3);
      chk("issues ch0", 32'(iss[0] - n), 32'h2);
      chk("irq0 done", 32'(irq0), 32'h1);
      rd(12'h40c, 32'h1, "status0");
      wr(12'h40c, rv);
      rd(12'h400, 32'h0, "raw cleared");
      chk("irq0 cleared", 32'(irq0), 32'h0);
      n = iss[0];
      wr(12'h00c, 32'h3);
      cyc(1);
      wbusy(0, 1'b0);
      chk("count trigger", 32'(iss[0] - n), 32'h3);
      wr(12'h40c, 32'h1);
      wr(12'h00c, 32'h0);
      cyc(2);
      chk("busy0 null", 32'(chan_busy[0]), 32'h0);
   endtask
   task automatic t_null;
      wr(12'h018, 32'h1ff);
      wr(12'h01c, 32'h0);
      cyc(2);
      chk("busy1 null", 32'(chan_busy[1]), 32'h0);
      rd(12'h400, 32'h2, "raw null");
      wr(12'h40c, 32'h2);
      wr(12'h01c, 32'h1);
      cyc(1);
      wbusy(1, 1'b0);
      cyc(3);
      rd(12'h400, 32'h0, "raw quiet done");
   endtask
   task automatic t_chain;
      int n;
      wr(12'h038, 32'h3fd);
      wr(12'h030, 32'h3);
      wr(12'h028, 32'h3fd);
      n = iss[3];
      wr(12'h02c, 32'h1);
      cyc(1);
      wbusy(2, 1'b0);
      chk("chain start", 32'(chan_busy[3]), 32'h1);
      stall <= 1'b1;
      wr(12'h03c, 32'h5);
      cyc(4);
      stall <= 1'b0;
      wbusy(3, 1'b0);
      chk("issues ch3", 32'(iss[3] - n), 32'h3);
      cyc(4);
      chk("no self chain", 32'(chan_busy), 32'h0);
   endtask
   task automatic t_pace;
      int n;
      int m;
      logic [5:0] s;
      wr(12'h430, 32'h14);
      for (int k = 0; k < 44; k++) begin
         s = (k < 40) ? 6'(k) : 6'(k + 19); // every request number and timer
         if (k >= 40) begin
            wr(12'h420 + 12'(4 * (k - 40)), 32'h0001_0004);
         end
         wr(12'h048, {20'h0, 4'h4, s, 2'b01});
         n = iss[4];
         m = snf;
         wr(12'h04c, 32'h2);
         if (k < 40) begin
            dreq[(k + 1) % 40] <= 1'b1; // pulse a neighbouring request line that channel 4 does not select
            cyc(1);
            dreq <= '0;
            cyc(6);
            chk("unselected req", 32'(xfer_req[4]), 32'h0);
            repeat (2) begin
               dreq[k] <= 1'b1;
               cyc(1);
               dreq <= '0;
               cyc(3);
            end
         end
         cyc(1);
         wbusy(4, 1'b0);
         chk("paced issues", 32'(iss[4] - n), 32'h2);
         chk("sniff strobes", 32'(snf - m), 32'h2);
         if (k >= 40) begin
            wr(12'h420 + 12'(4 * (k - 40)), 32'h0);
         end
      end
   endtask
   task automatic t_force;
      wr(12'h408, 32'h1);
      cyc(3);
      chk("force line0", 32'(irq0), 32'h1);
      chk("line1 apart", 32'(irq1), 32'h0);
      wr(12'h408, 32'h0);
      wr(12'h414, 32'h800);
      cyc(3);
      chk("force line1", 32'(irq1), 32'h1);
      chk("line0 apart", 32'(irq0), 32'h0);
      wr(12'h414, 32'h0);
   endtask
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs;
      t_start;
      t_null;
      t_chain;
      t_pace;
      t_force;
      results;
   end
endmodule
`default_nettype wire
